/* File: bench/msptqc_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port checks
module msptqc_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// frames
	input wire msptqc_pkg::msptqc_frame_t frame_in,
	input wire msptqc_pkg::msptqc_verdict_t verdict_out,
	input wire msptqc_pkg::msptqc_wred_t wred_out
);
	wire logic [13:0] widx;
	wire logic addr_ok;
	assign widx = paddr[15:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (widx == 14'h370 || widx == 14'h378 || widx == 14'h37c || widx == 14'h37d);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	one_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("pready not after one wait");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access phase");
	bad_addr_a: assert property (pready && !addr_ok |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
	good_addr_a: assert property (pready && addr_ok |-> !pslverr) else $error("mapped access refused");
	rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("prdata outside read answer");
	rsvd_high_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	verdict_lat_a: assert property (!$past(rst) |-> verdict_out.valid == $past(frame_in.valid)) else $error("verdict latency");
	idle_zero_a: assert property (!verdict_out.valid |-> verdict_out[5:0] == 6'h00) else $error("idle verdict not zero");
	mirror_cause_a: assert property (!$past(rst) |-> verdict_out.mirror == ($past(frame_in.valid) && ($past(frame_in.src_sniff) || $past(frame_in.dst_sniff))) || !$past(frame_in.src_sniff) || !$past(frame_in.dst_sniff)) else $error("mirror mismatch");
	host_cause_a: assert property (verdict_out.to_host |-> $past(frame_in.is_ipv4 && frame_in.ip_proto == 8'h02 || frame_in.is_ipv6)) else $error("to_host without cause");
	wred_reset_a: assert property ($fell(rst) |-> wred_out == 6'h39) else $error("colour map reset value");
	host_c: cover property (verdict_out.to_host);
	mirror_c: cover property (verdict_out.mirror);
	err_c: cover property (pready && pslverr);
endmodule
bind msptqc_top msptqc_assertions u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_in(frame_in),
	.verdict_out(verdict_out), .wred_out(wred_out));
`default_nettype wire

/* File: bench/msptqc_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module msptqc_tb_top;
	typedef struct packed {
		logic [7:0] gc, ev, gen;
		logic [1:0] kind;
		logic [7:0] nh, hbh;
		logic [1:0] sd, pt;
		logic [3:0] qos;
		logic [5:0] exp;
	} msptqc_row_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr;
	msptqc_pkg::msptqc_frame_t frame_in = '0;
	msptqc_pkg::msptqc_frame_t fr;
	msptqc_pkg::msptqc_verdict_t verdict_out;
	msptqc_pkg::msptqc_wred_t wred_out;
	msptqc_row_t rows [20];
	logic [15:0] adr [4] = '{16'hdc0, 16'hde0, 16'hdf0, 16'hdf4};
	logic [7:0] full [4] = '{8'h4d, 8'h3f, 8'h8f, 8'h8f};
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;

	always #20 mclk = ~mclk;

	msptqc_top u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_in(frame_in), .verdict_out(verdict_out), .wred_out(wred_out));

	// ==========================================================
	// bus and report tasks
	task automatic tally_and_finish;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		// request stands until pready is seen high at a rising edge
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("unexpected pready exp 1 got %b", pready);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic ee);
		apb(1'b0, a, 8'h00, 4'h0);
		`CHK("prdata", {24'h0, e}, rdat)
		`CHK("pslverr", ee, rerr)
	endtask

	// hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			tally_and_finish;
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		rows = '{
			'{8'h40, 8'h0f, 8'h0f, 2'h1, 8'h02, 8'h00, 2'h2, 2'h0, 4'h5, 6'h35},
			'{8'h00, 8'h0f, 8'h0f, 2'h1, 8'h02, 8'h00, 2'h1, 2'h0, 4'h5, 6'h15},
			'{8'h41, 8'h0f, 8'h0f, 2'h1, 8'h11, 8'h00, 2'h2, 2'h0, 4'h5, 6'h05},
			'{8'h05, 8'h0f, 8'h0f, 2'h2, 8'h3a, 8'h00, 2'h3, 2'h0, 4'h5, 6'h35},
			'{8'h04, 8'h0f, 8'h0f, 2'h2, 8'h01, 8'h00, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h04, 8'h0f, 8'h0f, 2'h2, 8'h00, 8'h3a, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h04, 8'h0f, 8'h0f, 2'h2, 8'h2b, 8'h00, 2'h0, 2'h0, 4'h5, 6'h05},
			'{8'h00, 8'h0f, 8'h0f, 2'h2, 8'h3a, 8'h00, 2'h0, 2'h0, 4'h5, 6'h05},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h2b, 8'h00, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h2c, 8'h00, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h32, 8'h00, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h33, 8'h00, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h3c, 8'h00, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h00, 8'h3c, 2'h0, 2'h0, 4'h5, 6'h25},
			'{8'h0c, 8'h0f, 8'h0f, 2'h2, 8'h3a, 8'h00, 2'h0, 2'h0, 4'h5, 6'h05},
			'{8'h00, 8'h0f, 8'h0f, 2'h0, 8'h00, 8'h00, 2'h0, 2'h2, 4'h5, 6'h05},
			'{8'h00, 8'h83, 8'h0f, 2'h0, 8'h00, 8'h00, 2'h0, 2'h2, 4'h5, 6'h03},
			'{8'h00, 8'h0f, 8'h8a, 2'h0, 8'h00, 8'h00, 2'h0, 2'h1, 4'h2, 6'h0a},
			'{8'h00, 8'h83, 8'h0a, 2'h0, 8'h00, 8'h00, 2'h0, 2'h1, 4'h2, 6'h02},
			'{8'h00, 8'h83, 8'h8a, 2'h0, 8'h00, 8'h00, 2'h0, 2'h3, 4'h2, 6'h03}};
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			apb(1'b1, 16'hdc0, rows[i].gc, 4'h1);
			apb(1'b1, 16'hdf0, rows[i].ev, 4'h1);
			apb(1'b1, 16'hdf4, rows[i].gen, 4'h1);
			fr = '0;
			fr.valid = 1'b1;
			{fr.is_ipv6, fr.is_ipv4} = rows[i].kind;
			fr.ip_proto = rows[i].nh;
			fr.next_hdr = rows[i].nh;
			fr.hbh_next_hdr = rows[i].hbh;
			{fr.src_sniff, fr.dst_sniff} = rows[i].sd;
			{fr.ptp_event, fr.ptp_general} = rows[i].pt;
			fr.qos_prio = rows[i].qos;
			@(posedge mclk);
			frame_in <= fr;
			@(posedge mclk);
			frame_in <= '0;
			#1;
			`CHK("verdict", {1'b1, rows[i].exp}, verdict_out)
		end
		// second reset in mid-run, then reset values
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK("wred_out", 6'h39, wred_out)
		rd(16'hdc0, 8'h00, 1'b0);
		rd(16'hde0, 8'h39, 1'b0);
		rd(16'hdf0, 8'h0f, 1'b0);
		rd(16'hdf4, 8'h0f, 1'b0);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, adr[k], 8'hff, 4'h1);
			rd(adr[k], full[k], 1'b0);
		end
		`CHK("wred_out", 6'h3f, wred_out)
		// strobe off: write dropped without error
		apb(1'b1, 16'hde0, 8'h00, 4'h0);
		rd(16'hde0, 8'h3f, 1'b0);
		rd(16'hdc4, 8'h00, 1'b1);
		rd(16'hdc1, 8'h00, 1'b1);
		tally_and_finish;
	end
endmodule
`default_nettype wire

/* File: hw/msptqc_nh_match.sv */
`timescale 1ns/1ns
`default_nettype none

module msptqc_nh_match (
	// selection
	input wire logic ext_hdr_opt,
	input wire logic [7:0] hdr,
	// result
	output logic hit
);

	wire logic ext_hit;
	wire logic icmp_hit;

	assign ext_hit = (hdr == msptqc_pkg::NH_ROUTING) || (hdr == msptqc_pkg::NH_FRAGMENT) ||
		(hdr == msptqc_pkg::NH_ESP) || (hdr == msptqc_pkg::NH_AUTH) || (hdr == msptqc_pkg::NH_DEST_OPT);
	assign icmp_hit = (hdr == msptqc_pkg::NH_ICMP) || (hdr == msptqc_pkg::NH_ICMPV6);
	assign hit = ext_hdr_opt ? ext_hit : icmp_hit;

endmodule

`default_nettype wire

/* File: hw/msptqc_pkg.sv */
package msptqc_pkg;

	// ==================================================================
	// register map (word index; byte address is four times the index)
	localparam logic [11:0] IDX_GLOBAL_CTRL = 12'h370;
	localparam logic [11:0] IDX_WRED_MAP = 12'h378;
	localparam logic [11:0] IDX_PTP_EVENT = 12'h37c;
	localparam logic [11:0] IDX_PTP_GENERAL = 12'h37d;

	// ==================================================================
	// field positions
	localparam int GC_IGMP_EN_BIT = 6;
	localparam int GC_MLD_OPT_BIT = 3;
	localparam int GC_MLD_EN_BIT = 2;
	localparam int GC_SNIFF_AND_BIT = 0;
	localparam int WRED_RED_LSB = 4;
	localparam int WRED_YELLOW_LSB = 2;
	localparam int WRED_GREEN_LSB = 0;
	localparam int PTP_OVR_BIT = 7;
	localparam int PTP_PRIO_LSB = 0;

	// ==================================================================
	// reset values
	localparam logic RST_IGMP_EN = 1'h0;
	localparam logic RST_MLD_OPT = 1'h0;
	localparam logic RST_MLD_EN = 1'h0;
	localparam logic RST_SNIFF_AND = 1'h0;
	localparam logic [1:0] RST_WRED_RED = 2'h3;
	localparam logic [1:0] RST_WRED_YELLOW = 2'h2;
	localparam logic [1:0] RST_WRED_GREEN = 2'h1;
	localparam logic RST_PTP_OVR = 1'h0;
	localparam logic [3:0] RST_PTP_PRIO = 4'hf;

	// ==================================================================
	// header codes
	localparam logic [7:0] PROTO_IGMP = 8'h02;
	localparam logic [7:0] NH_HOP_BY_HOP = 8'h00;
	localparam logic [7:0] NH_ICMP = 8'h01;
	localparam logic [7:0] NH_ICMPV6 = 8'h3a;
	localparam logic [7:0] NH_ROUTING = 8'h2b;
	localparam logic [7:0] NH_FRAGMENT = 8'h2c;
	localparam logic [7:0] NH_ESP = 8'h32;
	localparam logic [7:0] NH_AUTH = 8'h33;
	localparam logic [7:0] NH_DEST_OPT = 8'h3c;

	// ==================================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic is_ipv4;
		logic [7:0] ip_proto;
		logic is_ipv6;
		logic [7:0] next_hdr;
		logic [7:0] hbh_next_hdr;
		logic src_sniff;
		logic dst_sniff;
		logic ptp_event;
		logic ptp_general;
		logic [3:0] qos_prio;
	} msptqc_frame_t;

	typedef struct packed {
		logic valid;
		logic to_host;
		logic mirror;
		logic [3:0] prio;
	} msptqc_verdict_t;

	typedef struct packed {
		logic [1:0] red;
		logic [1:0] yellow;
		logic [1:0] green;
	} msptqc_wred_t;

endpackage

/* File: hw/msptqc_prio_sel.sv */
`timescale 1ns/1ns
`default_nettype none

module msptqc_prio_sel (
	// settings
	input wire logic override,
	input wire logic [3:0] forced_prio,
	// frame
	input wire logic [3:0] qos_prio,
	output logic [3:0] prio
);

	// forced value wins only while the override bit is set
	assign prio = override ? forced_prio : qos_prio;

endmodule

`default_nettype wire

/* File: hw/msptqc_top.sv */
// Notes on behaviour
// - with IGMP snooping enabled, every IGMP packet goes to the host port.
// - with MLD snooping enabled, every MLD packet goes to the host port.
// - option set: MLD is next header 43,44,50,51,60, or via hop-by-hop.
// - option clear: MLD is next header 1 or 58, or via hop-by-hop.
// - sniff select set: mirror only when source and destination both match.
// - sniff select clear (reset): mirror when source or destination matches.
// - colour map: red 5:4 reset 3, yellow 3:2 reset 2, green 1:0 reset 1.
// - event override clear: event messages keep their QoS priority.
// - event override set: event messages use bits 3:0, reset 15.
// - general override clear: general messages keep their QoS priority.
// - general override set: general messages use bits 3:0, reset 15.
`timescale 1ns/1ns
`default_nettype none

module msptqc_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frame classification
	input wire msptqc_pkg::msptqc_frame_t frame_in,
	output msptqc_pkg::msptqc_verdict_t verdict_out,
	// colour codes for the dropper
	output msptqc_pkg::msptqc_wred_t wred_out
);

	// ==================================================================
	// bus decode
	wire logic [13:0] word_idx;
	wire logic aligned;
	wire logic hit_gc;
	wire logic hit_wred;
	wire logic hit_pev;
	wire logic hit_pgen;
	wire logic mapped;
	wire logic access;
	wire logic commit;
	wire logic wr_lane0;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	assign word_idx = paddr[15:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign hit_gc = aligned && (word_idx == {2'h0, msptqc_pkg::IDX_GLOBAL_CTRL});
	assign hit_wred = aligned && (word_idx == {2'h0, msptqc_pkg::IDX_WRED_MAP});
	assign hit_pev = aligned && (word_idx == {2'h0, msptqc_pkg::IDX_PTP_EVENT});
	assign hit_pgen = aligned && (word_idx == {2'h0, msptqc_pkg::IDX_PTP_GENERAL});
	assign mapped = hit_gc || hit_wred || hit_pev || hit_pgen;
	// one wait state: pready rises on the second access cycle
	assign access = psel && penable && !pready_q;
	assign commit = psel && penable && pready_q;
	// only lane 0 carries register bits, the upper lanes are ignored
	assign wr_lane0 = commit && pwrite && pstrb[0] && mapped;

	// ==================================================================
	// control registers
	logic igmp_en_q, igmp_en_d;
	logic mld_opt_q, mld_opt_d;
	logic mld_en_q, mld_en_d;
	logic sniff_and_q, sniff_and_d;
	msptqc_pkg::msptqc_wred_t wred_q, wred_d;
	logic pev_ovr_q, pev_ovr_d;
	logic [3:0] pev_prio_q, pev_prio_d;
	logic pgen_ovr_q, pgen_ovr_d;
	logic [3:0] pgen_prio_q, pgen_prio_d;

	// reserved positions are simply not stored
	assign igmp_en_d = (wr_lane0 && hit_gc) ? pwdata[msptqc_pkg::GC_IGMP_EN_BIT] : igmp_en_q;
	assign mld_opt_d = (wr_lane0 && hit_gc) ? pwdata[msptqc_pkg::GC_MLD_OPT_BIT] : mld_opt_q;
	assign mld_en_d = (wr_lane0 && hit_gc) ? pwdata[msptqc_pkg::GC_MLD_EN_BIT] : mld_en_q;
	assign sniff_and_d = (wr_lane0 && hit_gc) ? pwdata[msptqc_pkg::GC_SNIFF_AND_BIT] : sniff_and_q;
	assign wred_d.red = (wr_lane0 && hit_wred) ?
		pwdata[msptqc_pkg::WRED_RED_LSB +: 2] : wred_q.red;
	assign wred_d.yellow = (wr_lane0 && hit_wred) ?
		pwdata[msptqc_pkg::WRED_YELLOW_LSB +: 2] : wred_q.yellow;
	assign wred_d.green = (wr_lane0 && hit_wred) ?
		pwdata[msptqc_pkg::WRED_GREEN_LSB +: 2] : wred_q.green;
	assign pev_ovr_d = (wr_lane0 && hit_pev) ? pwdata[msptqc_pkg::PTP_OVR_BIT] : pev_ovr_q;
	assign pev_prio_d = (wr_lane0 && hit_pev) ? pwdata[msptqc_pkg::PTP_PRIO_LSB +: 4] : pev_prio_q;
	assign pgen_ovr_d = (wr_lane0 && hit_pgen) ? pwdata[msptqc_pkg::PTP_OVR_BIT] : pgen_ovr_q;
	assign pgen_prio_d = (wr_lane0 && hit_pgen) ? pwdata[msptqc_pkg::PTP_PRIO_LSB +: 4] : pgen_prio_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			igmp_en_q <= msptqc_pkg::RST_IGMP_EN;
			mld_opt_q <= msptqc_pkg::RST_MLD_OPT;
			mld_en_q <= msptqc_pkg::RST_MLD_EN;
			sniff_and_q <= msptqc_pkg::RST_SNIFF_AND;
		end else begin
			igmp_en_q <= igmp_en_d;
			mld_opt_q <= mld_opt_d;
			mld_en_q <= mld_en_d;
			sniff_and_q <= sniff_and_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wred_q.red <= msptqc_pkg::RST_WRED_RED;
			wred_q.yellow <= msptqc_pkg::RST_WRED_YELLOW;
			wred_q.green <= msptqc_pkg::RST_WRED_GREEN;
		end else begin
			wred_q <= wred_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pev_ovr_q <= msptqc_pkg::RST_PTP_OVR;
			pev_prio_q <= msptqc_pkg::RST_PTP_PRIO;
			pgen_ovr_q <= msptqc_pkg::RST_PTP_OVR;
			pgen_prio_q <= msptqc_pkg::RST_PTP_PRIO;
		end else begin
			pev_ovr_q <= pev_ovr_d;
			pev_prio_q <= pev_prio_d;
			pgen_ovr_q <= pgen_ovr_d;
			pgen_prio_q <= pgen_prio_d;
		end
	end

	// ==================================================================
	// read-back
	wire logic [7:0] rd_gc;
	wire logic [7:0] rd_wred;
	wire logic [7:0] rd_pev;
	wire logic [7:0] rd_pgen;
	wire logic [7:0] rd_byte;

	// reserved bits are tied low here rather than stored
	assign rd_gc = {1'h0, igmp_en_q, 2'h0, mld_opt_q, mld_en_q, 1'h0, sniff_and_q};
	assign rd_wred = {2'h0, wred_q.red, wred_q.yellow, wred_q.green};
	assign rd_pev = {pev_ovr_q, 3'h0, pev_prio_q};
	assign rd_pgen = {pgen_ovr_q, 3'h0, pgen_prio_q};
	assign rd_byte = hit_gc ? rd_gc :
		hit_wred ? rd_wred :
		hit_pev ? rd_pev :
		hit_pgen ? rd_pgen : 8'h00;

	// ==================================================================
	// apb answer
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready_q <= 1'h0;
			pslverr_q <= 1'h0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= access;
			pslverr_q <= access && !mapped;
			// data is captured one cycle early so it stands with pready
			prdata_q <= (access && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// ==================================================================
	// frame classification
	wire logic nh_hit;
	wire logic hbh_hit;
	wire logic is_igmp;
	wire logic is_mld;
	wire logic snoop;
	wire logic sniff_any;
	wire logic sniff_both;
	wire logic mirror;
	wire logic [3:0] pev_prio;
	wire logic [3:0] pgen_prio;
	wire logic [3:0] frame_prio;

	msptqc_nh_match u_nh_match (
		.ext_hdr_opt(mld_opt_q),
		.hdr(frame_in.next_hdr),
		.hit(nh_hit)
	);

	msptqc_nh_match u_hbh_match (
		.ext_hdr_opt(mld_opt_q),
		.hdr(frame_in.hbh_next_hdr),
		.hit(hbh_hit)
	);

	assign is_igmp = frame_in.is_ipv4 && (frame_in.ip_proto == msptqc_pkg::PROTO_IGMP);
	// a hop-by-hop header is looked through once, no deeper
	assign is_mld = frame_in.is_ipv6 &&
		(nh_hit || ((frame_in.next_hdr == msptqc_pkg::NH_HOP_BY_HOP) && hbh_hit));
	assign snoop = (igmp_en_q && is_igmp) || (mld_en_q && is_mld);

	// port matches come from the per-port ingress settings outside this block
	assign sniff_any = frame_in.src_sniff || frame_in.dst_sniff;
	assign sniff_both = frame_in.src_sniff && frame_in.dst_sniff;
	assign mirror = sniff_and_q ? sniff_both : sniff_any;

	msptqc_prio_sel u_event_prio (
		.override(pev_ovr_q),
		.forced_prio(pev_prio_q),
		.qos_prio(frame_in.qos_prio),
		.prio(pev_prio)
	);

	msptqc_prio_sel u_general_prio (
		.override(pgen_ovr_q),
		.forced_prio(pgen_prio_q),
		.qos_prio(frame_in.qos_prio),
		.prio(pgen_prio)
	);

	// event takes precedence should a classifier ever flag both
	assign frame_prio = frame_in.ptp_event ? pev_prio :
		frame_in.ptp_general ? pgen_prio : frame_in.qos_prio;

	// ==================================================================
	// registered verdict
	msptqc_pkg::msptqc_verdict_t verdict_q, verdict_d;
	msptqc_pkg::msptqc_wred_t wred_out_q;

	assign verdict_d.valid = frame_in.valid;
	assign verdict_d.to_host = frame_in.valid && snoop;
	assign verdict_d.mirror = frame_in.valid && mirror;
	assign verdict_d.prio = frame_in.valid ? frame_prio : 4'h0;

	always_ff @(posedge mclk) begin
		if (rst) begin
			verdict_q <= '0;
			wred_out_q.red <= msptqc_pkg::RST_WRED_RED;
			wred_out_q.yellow <= msptqc_pkg::RST_WRED_YELLOW;
			wred_out_q.green <= msptqc_pkg::RST_WRED_GREEN;
		end else begin
			verdict_q <= verdict_d;
			wred_out_q <= wred_q;
		end
	end

	assign verdict_out = verdict_q;
	assign wred_out = wred_out_q;

endmodule

`default_nettype wire
